// file: src/spi_control_configuration.sv
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/100ps
`include "spi_ctrl_params.svh"
module spi_control_configuration
   import spi_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdata,
   // Processor state
   input wire logic waitMode,
   // Interrupt
   output logic irq,
   // Serial clock pin
   input wire logic sclkIn,
   output logic sclkOut,
   output logic sclkOeN,
   // Master-out data pin
   input wire logic mosiIn,
   output logic mosiOut,
   output logic mosiOeN,
   // Master-in data pin
   input wire logic misoIn,
   output logic misoOut,
   output logic misoOeN,
   // Select pin, active low
   input wire logic selNIn,
   output logic selNOut,
   output logic selOeN
);

   state_t s_reg;
   state_t s_next;
   logic [4:0] pinSync;
   logic sclkS;
   logic mosiS;
   logic misoS;
   logic selNS;
   logic tick;
   logic timerRun;

   // ==========================================================
   // Shift one bit in at the end opposite the outgoing bit
   function automatic logic [7:0] shiftIn(input logic [7:0] v,
                                           input logic b,
                                           input logic lsbFirst);
      if (lsbFirst) begin
         shiftIn = {b, v[7:1]};
      end else begin
         shiftIn = {v[6:0], b};
      end
   endfunction

   // ==========================================================
   // Pin synchronisers
   spi_pin_sync #(
      .W(5)
   ) u_sync (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .d({sclkIn, mosiIn, misoIn, selNIn, 1'b1}),
      .q(pinSync)
   );

   assign sclkS = pinSync[4];
   assign mosiS = pinSync[3];
   assign misoS = pinSync[2];
   assign selNS = pinSync[1];

   // ==========================================================
   // Master half-bit timer
   spi_bit_timer #(
      .CW(11)
   ) u_timer (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .run(timerRun),
      .prescale(s_reg.baud[6:4]),
      .rate(s_reg.baud[2:0]),
      .tick(tick)
   );

   // ==========================================================
   // Next-state logic
   always_comb begin
      logic en;
      logic master_select;
      logic clock_polarity;
      logic clock_phase;
      logic lsbf;
      logic single_wire_select;
      logic single_wire_output_enable;
      logic mode_fault_enable;
      logic select_output_enable;
      logic run;
      logic wrData;
      logic inBit;
      logic edgeSeen;
      logic lead;
      logic sampleNow;
      logic outBit;
      logic [4:0] h;
      logic [7:0] v;
      en = 1'b0;
      master_select = 1'b0;
      clock_polarity = 1'b0;
      clock_phase = 1'b0;
      lsbf = 1'b0;
      single_wire_select = 1'b0;
      single_wire_output_enable = 1'b0;
      mode_fault_enable = 1'b0;
      select_output_enable = 1'b0;
      run = 1'b0;
      wrData = 1'b0;
      inBit = 1'b0;
      edgeSeen = 1'b0;
      lead = 1'b0;
      sampleNow = 1'b0;
      outBit = 1'b0;
      h = 5'h00;
      v = 8'h00;
      s_next = s_reg;
      s_next.rdata = 8'h00;

      // Register writes
      if (regWr) begin
         case (regAddr)
            `OFS_CTRL1: begin
               s_next.ctrl1 = regWdata; // [RQ18]
               if (s_reg.modfArm) begin
                  s_next.mode_fault_flag = 1'b0;
                  s_next.modfArm = 1'b0;
               end
            end
            `OFS_CTRL2: s_next.ctrl2 = regWdata & `CTRL2_MASK; // [RQ11]
            `OFS_BAUD: s_next.baud = regWdata & `BAUD_MASK;
            `OFS_DATA: begin
               wrData = 1'b1;
               s_next.txBuf = regWdata;
               s_next.txFull = 1'b1;
               s_next.txEmpty = 1'b0;
            end
            `OFS_EVT: s_next.evt = s_reg.evt & ~regWdata[2:0];
            `OFS_MASK: s_next.mask = regWdata[2:0];
            default: ;
         endcase
      end

      // Register reads
      if (regRd) begin
         case (regAddr)
            `OFS_CTRL1: s_next.rdata = s_reg.ctrl1; // [RQ18]
            `OFS_CTRL2: s_next.rdata = s_reg.ctrl2; // [RQ11]
            `OFS_BAUD: s_next.rdata = s_reg.baud;
            `OFS_STATUS: begin
               s_next.rdata[`B_ST_RXF] = s_reg.rxFull;
               s_next.rdata[`B_ST_TXE] = s_reg.txEmpty;
               s_next.rdata[`B_ST_MODE_FAULT_FLAG] = s_reg.mode_fault_flag;
               s_next.rxArm = s_reg.rxFull;
               s_next.modfArm = s_reg.mode_fault_flag;
            end
            `OFS_DATA: begin
               s_next.rdata = s_reg.rxBuf;
               if (s_reg.rxArm) begin
                  s_next.rxFull = 1'b0;
                  s_next.rxArm = 1'b0;
               end
            end
            `OFS_EVT: s_next.rdata = {5'h00, s_reg.evt};
            `OFS_MASK: s_next.rdata = {5'h00, s_reg.mask};
            default: s_next.rdata = 8'h00;
         endcase
      end

      // Live configuration
      en = s_reg.ctrl1[`B_EN];
      master_select = s_reg.ctrl1[`B_MASTER_SELECT]; // [RQ4]
      clock_polarity = s_reg.ctrl1[`B_CLOCK_POLARITY];
      clock_phase = s_reg.ctrl1[`B_CLOCK_PHASE];
      lsbf = s_reg.ctrl1[`B_LSBF]; // [RQ7]
      select_output_enable = s_reg.ctrl1[`B_SELECT_OUTPUT_ENABLE];
      single_wire_select = s_reg.ctrl2[`B_SINGLE_WIRE_SELECT];
      single_wire_output_enable = s_reg.ctrl2[`B_SINGLE_WIRE_OUTPUT_ENABLE];
      mode_fault_enable = s_reg.ctrl2[`B_MODE_FAULT_ENABLE];
      run = !(s_reg.ctrl2[`B_SWAI] && waitMode); // [RQ15]
      if (single_wire_select) begin
         inBit = master_select ? mosiS : misoS; // [RQ14]
      end else begin
         inBit = master_select ? misoS : mosiS;
      end

      // Transfer engine
      if (!en) begin
         s_next.xfer = XFER_IDLE; // [RQ2]
         s_next.half = 5'h00;
         s_next.cnt = 4'h0;
         s_next.sh = 8'h00;
         s_next.txBuf = 8'h00;
         s_next.rxBuf = 8'h00;
         s_next.txFull = 1'b0;
         s_next.rxFull = 1'b0;
         s_next.rxArm = 1'b0;
         s_next.txEmpty = 1'b1;
      end else if (run && master_select) begin
         if (mode_fault_enable && !select_output_enable && !selNS) begin
            s_next.mode_fault_flag = 1'b1; // [RQ8]
            s_next.evt[`EV_MODE_FAULT_FLAG] = 1'b1;
            s_next.xfer = XFER_IDLE;
            s_next.half = 5'h00;
         end else begin
            case (s_reg.xfer)
               XFER_IDLE: begin
                  if (s_reg.txFull) begin
                     s_next.sh = s_reg.txBuf;
                     s_next.txFull = wrData;
                     s_next.txEmpty = !wrData;
                     s_next.evt[`EV_TXE] = 1'b1;
                     s_next.xfer = XFER_RUN;
                     s_next.half = 5'h00;
                  end
               end
               XFER_RUN: begin
                  if (tick) begin
                     h = s_reg.half + 5'd1;
                     s_next.half = h;
                     if (h[0]) begin
                        s_next.rxBit = inBit; // [RQ6]
                     end else begin
                        v = shiftIn(s_reg.sh, s_reg.rxBit, lsbf); // [RQ7]
                        s_next.sh = v;
                        if (h == `HALF_LAST) begin
                           s_next.rxBuf = v;
                           s_next.rxFull = 1'b1;
                           s_next.evt[`EV_RX] = 1'b1;
                           s_next.xfer = XFER_IDLE;
                           s_next.half = 5'h00;
                        end
                     end
                  end
               end
               default: s_next.xfer = XFER_IDLE;
            endcase
         end
      end else if (run) begin
         // Slave: select pin always the select input
         if (s_reg.xfer == XFER_IDLE && s_reg.txFull) begin
            s_next.sh = s_reg.txBuf;
            s_next.txFull = wrData;
            s_next.txEmpty = !wrData;
            s_next.evt[`EV_TXE] = 1'b1;
            s_next.xfer = XFER_RUN;
         end
         edgeSeen = sclkS != s_reg.sclkPrev;
         lead = sclkS != clock_polarity; // [RQ5]
         sampleNow = clock_phase ? !lead : lead; // [RQ6]
         if (selNS) begin
            s_next.cnt = 4'h0; // [RQ9]
         end else if (edgeSeen && sampleNow) begin
            v = shiftIn(s_next.sh, inBit, lsbf); // [RQ7]
            s_next.sh = v;
            s_next.cnt = s_reg.cnt + 4'd1;
            if (s_reg.cnt == `BITS_LAST) begin
               s_next.cnt = 4'h0;
               s_next.rxBuf = v;
               s_next.rxFull = 1'b1;
               s_next.evt[`EV_RX] = 1'b1;
               s_next.xfer = XFER_IDLE;
            end
         end
      end
      s_next.sclkPrev = sclkS;

      // Pin drive; all released by default
      outBit = lsbf ? s_next.sh[0] : s_next.sh[7];
      s_next.sclkOut = 1'b0;
      s_next.sclkOeN = 1'b1;
      s_next.mosiOut = 1'b0;
      s_next.mosiOeN = 1'b1;
      s_next.misoOut = 1'b0;
      s_next.misoOeN = 1'b1;
      s_next.selNOut = 1'b1;
      s_next.selOeN = 1'b1;
      if (s_next.ctrl1[`B_EN]) begin // [RQ16]
         if (master_select) begin
            s_next.sclkOeN = 1'b0;
            s_next.sclkOut = clock_polarity ^ (s_next.xfer == XFER_RUN &&
               (clock_phase ? !s_next.half[0] : s_next.half[0])); // [RQ5]
            s_next.mosiOut = outBit;
            s_next.mosiOeN = single_wire_select && !single_wire_output_enable; // [RQ12] [RQ13] [RQ17]
            if (mode_fault_enable && select_output_enable) begin
               s_next.selOeN = 1'b0; // [RQ8]
               s_next.selNOut = s_next.xfer != XFER_RUN;
            end
         end else begin
            s_next.misoOut = outBit;
            s_next.misoOeN = selNS || (single_wire_select && !single_wire_output_enable); // [RQ12] [RQ17]
         end
      end

      // Interrupt request
      s_next.irq = (s_next.ctrl1[`B_RXIE] &&
                    (s_next.rxFull || s_next.mode_fault_flag)) || // [RQ1]
                   (s_next.ctrl1[`B_TXIE] && s_next.txEmpty) || // [RQ3]
                   |(s_next.evt & s_next.mask);
   end

   assign timerRun = s_reg.ctrl1[`B_EN] && s_reg.ctrl1[`B_MASTER_SELECT] &&
                     s_reg.xfer == XFER_RUN &&
                     !(s_reg.ctrl2[`B_SWAI] && waitMode);

   // ==========================================================
   // State register
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s_reg <= '0;
         s_reg.ctrl1 <= `RST_CTRL1;
         s_reg.ctrl2 <= `RST_CTRL2;
         s_reg.baud <= `RST_BAUD;
         s_reg.txEmpty <= 1'b1;
         s_reg.xfer <= XFER_IDLE;
         s_reg.sclkOeN <= 1'b1;
         s_reg.mosiOeN <= 1'b1;
         s_reg.misoOeN <= 1'b1;
         s_reg.selNOut <= 1'b1;
         s_reg.selOeN <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // ==========================================================
   // Outputs
   assign regRdata = s_reg.rdata;
   assign irq = s_reg.irq;
   assign sclkOut = s_reg.sclkOut;
   assign sclkOeN = s_reg.sclkOeN;
   assign mosiOut = s_reg.mosiOut;
   assign mosiOeN = s_reg.mosiOeN;
   assign misoOut = s_reg.misoOut;
   assign misoOeN = s_reg.misoOeN;
   assign selNOut = s_reg.selNOut;
   assign selOeN = s_reg.selOeN;

endmodule

// file: src/spi_ctrl_params.svh
// Summary of operation
// [RQ1] Bit 7 set: interrupt while receive-full or mode-fault flag is set.
// [RQ2] Clearing enable halts transfer, clears buffers, rx-full, sets tx-empty.
// [RQ3] Bit 5 set: interrupt while transmit-empty flag is set.
// [RQ4] Bit 4 selects slave (0) or master (1).
// [RQ5] Bit 3 inverts the serial clock; 1 idles high.
// [RQ6] Bit 2: first clock edge mid first cycle (0) or at start (1).
// [RQ7] Bit 0 of control one: MSB first (0) or LSB first (1).
// [RQ8] Master select pin: GPIO, mode-fault input or automatic select output.
// [RQ9] Slave always uses select pin as active-low select input.
// [RQ10] Software never clears enable in the same write that changes phase.
// [RQ11] Control two implements bits 4,3,1,0; others read zero.
// [RQ12] Single-wire: output-enable bit 3 drives (1) or releases (0) line.
// [RQ13] Without single-wire mode the output-enable bit has no effect.
// [RQ14] Bit 0 of control two: single-wire on MISO (slave) or MOSI (master).
// [RQ15] Bit 1 of control two stops the port clocks in wait mode.
// [RQ16] While disabled, all four pins are released to general I/O.
// [RQ17] In single-wire mode the unused data pin is released.
// [RQ18] Control bits read back as written; writes act next cycle.
`ifndef SPI_CTRL_PARAMS_SVH
`define SPI_CTRL_PARAMS_SVH

// ==========================================================
// Register offsets
`define OFS_CTRL1 8'h00
`define OFS_CTRL2 8'h01
`define OFS_BAUD 8'h02
`define OFS_STATUS 8'h03
`define OFS_DATA 8'h04
`define OFS_EVT 8'h05
`define OFS_MASK 8'h06

// ==========================================================
// Control one fields
`define B_RXIE 7
`define B_EN 6
`define B_TXIE 5
`define B_MASTER_SELECT 4
`define B_CLOCK_POLARITY 3
`define B_CLOCK_PHASE 2
`define B_SELECT_OUTPUT_ENABLE 1
`define B_LSBF 0

// ==========================================================
// Control two fields
`define B_MODE_FAULT_ENABLE 4
`define B_SINGLE_WIRE_OUTPUT_ENABLE 3
`define B_SWAI 1
`define B_SINGLE_WIRE_SELECT 0
`define CTRL2_MASK 8'h1b

// ==========================================================
// Status, baud and event fields
`define B_ST_RXF 7
`define B_ST_TXE 5
`define B_ST_MODE_FAULT_FLAG 4
`define BAUD_MASK 8'h77
`define EV_RX 0
`define EV_MODE_FAULT_FLAG 1
`define EV_TXE 2

// ==========================================================
// Reset values and timing
`define RST_CTRL1 8'h00
`define RST_CTRL2 8'h00
`define RST_BAUD 8'h00
`define HALF_LAST 5'd16
`define BITS_LAST 4'd7

`endif

// file: src/spi_ctrl_pkg.sv
package spi_ctrl_pkg;

   typedef enum logic {XFER_IDLE, XFER_RUN} xfer_t;

   typedef struct packed {
      logic [7:0] ctrl1;
      logic [7:0] ctrl2;
      logic [7:0] baud;
      logic [2:0] evt;
      logic [2:0] mask;
      logic [7:0] txBuf;
      logic [7:0] rxBuf;
      logic [7:0] sh;
      logic txFull;
      logic rxFull;
      logic txEmpty;
      logic mode_fault_flag;
      logic rxArm;
      logic modfArm;
      xfer_t xfer;
      logic [4:0] half;
      logic rxBit;
      logic [3:0] cnt;
      logic sclkPrev;
      logic [7:0] rdata;
      logic irq;
      logic sclkOut;
      logic sclkOeN;
      logic mosiOut;
      logic mosiOeN;
      logic misoOut;
      logic misoOeN;
      logic selNOut;
      logic selOeN;
   } state_t;

endpackage

// file: src/spi_pin_sync.sv
`timescale 1ns/100ps
module spi_pin_sync #(
   parameter int W = 5
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Pins
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;

   // ==========================================================
   // Two-stage synchroniser
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         meta_reg <= '0;
         q <= '0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule

// file: src/spi_bit_timer.sv
`timescale 1ns/100ps
module spi_bit_timer #(
   parameter int CW = 11
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Control
   input wire logic run,
   input wire logic [2:0] prescale,
   input wire logic [2:0] rate,
   // Half-bit pulse
   output logic tick
);
   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] limit;

   // ==========================================================
   // Half period is (prescale+1) * 2^rate bus cycles
   assign limit = CW'(({{(CW-3){1'b0}}, prescale} + 1'b1) << rate);

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_reg <= '0;
         tick <= 1'b0;
      end else if (!run) begin
         cnt_reg <= '0;
         tick <= 1'b0;
      end else if (cnt_reg >= limit - 1'b1) begin
         cnt_reg <= '0;
         tick <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 1'b1;
         tick <= 1'b0;
      end
   end
endmodule

// file: verification/spi_ctrl_monitor.sv
`timescale 1ns/100ps
`include "spi_ctrl_params.svh"
module spi_ctrl_checker (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [7:0] regRdata,
   // Processor state and interrupt
   input wire logic waitMode,
   input wire logic irq,
   // Pins
   input wire logic sclkIn,
   input wire logic sclkOut,
   input wire logic sclkOeN,
   input wire logic mosiIn,
   input wire logic mosiOut,
   input wire logic mosiOeN,
   input wire logic misoIn,
   input wire logic misoOut,
   input wire logic misoOeN,
   input wire logic selNIn,
   input wire logic selNOut,
   input wire logic selOeN
);
   // ====
   // Shadow of the control registers
   logic [7:0] c1_reg;
   logic [7:0] c2_reg;
   logic [1:0] age_reg;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         c1_reg <= 8'h00;
         c2_reg <= 8'h00;
         age_reg <= 2'd0;
      end else begin
         if (regWr && regAddr == `OFS_CTRL1) c1_reg <= regWdata;
         if (regWr && regAddr == `OFS_CTRL2) begin
            c2_reg <= regWdata & `CTRL2_MASK;
         end
         if (regWr && regAddr[7:1] == 7'h00) age_reg <= 2'd0;
         else if (age_reg != 2'd3) age_reg <= age_reg + 2'd1;
      end
   end
   // ====
   // Properties
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   sequence s_on;
      age_reg == 2'd3 && c1_reg[6];
   endsequence
   sequence s_idle;
      (age_reg == 2'd3 && c1_reg[6] && c1_reg[4] && !selOeN && selNOut)[*2];
   endsequence
   property p_rd_one;
      regRd && regAddr == `OFS_CTRL1 |=> regRdata == $past(c1_reg);
   endproperty
   a_rd_one: assert property (p_rd_one) else $error("ctrl1 readback");
   property p_rd_two;
      regRd && regAddr == `OFS_CTRL2 |=> regRdata == $past(c2_reg);
   endproperty
   a_rd_two: assert property (p_rd_two) else $error("ctrl2 readback");
   property p_off;
      !c1_reg[6] && !$past(c1_reg[6]) |->
         sclkOeN && mosiOeN && misoOeN && selOeN;
   endproperty
   a_off: assert property (p_off) else $error("pins held when off");
   property p_dir;
      s_on |-> sclkOeN == !c1_reg[4] && (c1_reg[4] || selOeN && mosiOeN);
   endproperty
   a_dir: assert property (p_dir) else $error("role pin use");
   property p_one_wire;
      s_on ##0 (c1_reg[4] && c2_reg[0]) |->
         mosiOeN == !c2_reg[3] && misoOeN;
   endproperty
   a_one_wire: assert property (p_one_wire) else
      $error("single wire");
   property p_two_wire;
      s_on ##0 (c1_reg[4] && !c2_reg[0]) |-> !mosiOeN && misoOeN;
   endproperty
   a_two_wire: assert property (p_two_wire) else $error("two wire");
   property p_gpio;
      s_on ##0 (c1_reg[4] && !c2_reg[4]) |-> selOeN;
   endproperty
   a_gpio: assert property (p_gpio) else $error("select pin held");
   property p_idle_pol;
      s_idle |-> sclkOut == c1_reg[3];
   endproperty
   a_idle_pol: assert property (p_idle_pol) else $error("idle level");
   property p_wait;
      c2_reg[1] && waitMode && $past(waitMode) |->
         $stable(sclkOut) && $stable(mosiOut);
   endproperty
   a_wait: assert property (p_wait) else $error("runs in wait");
   property p_tx_irq;
      age_reg == 2'd3 && c1_reg[5] && !c1_reg[6] |-> irq;
   endproperty
   a_tx_irq: assert property (p_tx_irq) else $error("tx irq");
endmodule

bind spi_control_configuration spi_ctrl_checker spi_ctrl_checker_i (
   .sys_clk, .rstn, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
   .waitMode, .irq, .sclkIn, .sclkOut, .sclkOeN, .mosiIn, .mosiOut,
   .mosiOeN, .misoIn, .misoOut, .misoOeN, .selNIn, .selNOut, .selOeN
);

// file: verification/spi_slave_model.sv
`timescale 1ns/100ps
module spi_slave_model (
   // Link
   input wire logic selN,
   input wire logic sclk,
   input wire logic mosi,
   output logic miso,
   // Setup and result
   input wire logic clock_phase,
   input wire logic lsb,
   input wire logic [7:0] txByte,
   output logic [7:0] rxByte
);
   int edges;
   int k;
   initial begin
      miso = 1'b0;
      rxByte = 8'h00;
      edges = 0;
   end
   // ====
   // Frame start presents the first bit
   always @(negedge selN) begin
      edges = 0;
      miso = lsb ? txByte[0] : txByte[7];
   end
   // Released line shows the inverse of the last bit
   always @(posedge selN) miso = ~miso;
   // ====
   // Sample or shift on each clock edge
   always @(sclk) begin
      // Let a select edge of the same instant settle first
      #1;
      if (!selN && edges < 16) begin
         k = edges >> 1;
         if ((edges & 1) == int'(clock_phase)) begin
            rxByte[lsb ? k : 7 - k] = mosi;
         end else if (((edges + 1) >> 1) < 8) begin
            k = (edges + 1) >> 1;
            miso = lsb ? txByte[k] : txByte[7 - k];
         end
         edges++;
      end
   end
endmodule

// file: verification/test_spi_control_configuration.sv
`timescale 1ns/100ps
`include "spi_ctrl_params.svh"
module test_spi_control_configuration;
   logic sys_clk, rstn, regWr, regRd, waitMode, selDrvN, irq, pMiso;
   logic [7:0] regAddr, regWdata, regRdata, tb, pb, rxB, r;
   logic sclkOut, sclkOeN, mosiOut, mosiOeN, misoOut, misoOeN;
   logic selNOut, selOeN, rdSeen, x, sclkDrv;
   logic [7:0] expQ[$];
   int n_fail = 0;
   int checks = 0;
   int seed = 32'hd6af4c54;
   int i, w;
   wire sclkW = sclkOeN ? sclkDrv : sclkOut;
   wire mosiW = mosiOeN ? 1'b1 : mosiOut;
   wire misoW = misoOeN ? pMiso : misoOut;
   wire selW = selOeN ? selDrvN : selNOut;
   spi_control_configuration spi_control_configuration_i (
      .sys_clk, .rstn, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
      .waitMode, .irq, .sclkIn(sclkW), .sclkOut, .sclkOeN,
      .mosiIn(mosiW), .mosiOut, .mosiOeN, .misoIn(misoW), .misoOut,
      .misoOeN, .selNIn(selW), .selNOut, .selOeN);
   spi_slave_model spi_slave_model_i (.selN(selW), .sclk(sclkW),
      .mosi(mosiW), .miso(pMiso), .clock_phase(r[2]), .lsb(r[0]),
      .txByte(pb), .rxByte(rxB));
   // ====
   // Tasks
   task automatic close_out;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge sys_clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      expQ.push_back(exp);
      @(posedge sys_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge sys_clk);
      regRd <= 1'b0;
   endtask
   task automatic waitIrq(input logic v);
      for (w = 0; w < 600 && irq !== v; w++) @(posedge sys_clk);
      cmp({7'h00, irq}, {7'h00, v});
      if (w >= 600) close_out();
   endtask
   // ====
   // Clock and read data watcher
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial rdSeen = 1'b0;
   always @(posedge sys_clk) begin
      if (rdSeen) cmp(regRdata, expQ.pop_front());
      rdSeen = regRd;
   end
   // ====
   // Main sequence
   initial begin
      {rstn, regWr, regRd, waitMode, sclkDrv} = 5'h00;
      {selDrvN, regAddr, regWdata, pb, r} = {1'b1, 32'h0};
      repeat (20) @(posedge sys_clk);
      rstn <= 1'b1;
      rd(`OFS_CTRL1, 8'h00);
      rd(`OFS_CTRL2, 8'h00);
      wr(8'h07, 8'hff);
      rd(8'h07, 8'h00);
      tb = $random(seed);
      wr(`OFS_CTRL2, tb);
      rd(`OFS_CTRL2, tb & 8'h1b);
      tb = $random(seed) & 8'hbf;
      wr(`OFS_CTRL1, tb);
      rd(`OFS_CTRL1, tb);
      wr(`OFS_CTRL1, 8'h20);
      waitIrq(1'b1);
      wr(`OFS_CTRL1, 8'h00);
      waitIrq(1'b0);
      selDrvN <= 1'b0;
      for (i = 0; i < 8; i++) begin
         wr(`OFS_CTRL2, {4'h0, i[1], 2'b00, i[0]});
         wr(`OFS_CTRL1, {3'b010, i[2], 4'h0});
         repeat (4) @(posedge sys_clk);
         x = i[0] & ~i[1];
         cmp({sclkOeN, mosiOeN, misoOeN}, i[2] ? {2'b00, x, 1'b1} :
            {2'b11, x});
         wr(`OFS_CTRL1, 8'h00);
         repeat (3) @(posedge sys_clk);
         cmp({sclkOeN, mosiOeN, misoOeN, selOeN}, 8'h0f);
      end
      selDrvN <= 1'b1;
      wr(`OFS_BAUD, 8'h02);
      wr(`OFS_CTRL2, 8'h12);
      for (i = 0; i < 9; i++) begin
         r = 8'hd2 | {4'h0, i[1:0], 1'b0, i[2]};
         wr(`OFS_CTRL1, r);
         repeat (4) @(posedge sys_clk);
         cmp({7'h00, sclkOut}, {7'h00, r[3]});
         cmp({7'h00, irq}, 8'h00);
         tb = $random(seed);
         pb = $random(seed);
         wr(`OFS_DATA, tb);
         if (i[0]) begin
            repeat (10) @(posedge sys_clk);
            waitMode <= 1'b1;
            repeat (20) @(posedge sys_clk);
            waitMode <= 1'b0;
         end
         waitIrq(1'b1);
         cmp(rxB, tb);
         if (i < 8) begin
            rd(`OFS_STATUS, 8'ha0);
            rd(`OFS_DATA, pb);
            waitIrq(1'b0);
         end
         wr(`OFS_CTRL1, r & 8'hbf);
         if (i == 8) rd(`OFS_STATUS, 8'h20);
      end
      wr(`OFS_MASK, 8'h05);
      waitIrq(1'b1);
      wr(`OFS_MASK, 8'h00);
      waitIrq(1'b0);
      wr(`OFS_EVT, 8'h07);
      wr(`OFS_MASK, 8'h07);
      rd(`OFS_EVT, 8'h00);
      waitIrq(1'b0);
      wr(`OFS_CTRL2, 8'h10);
      wr(`OFS_CTRL1, 8'hd0);
      selDrvN <= 1'b0;
      waitIrq(1'b1);
      rd(`OFS_STATUS, 8'h30);
      selDrvN <= 1'b1;
      repeat (4) @(posedge sys_clk);
      wr(`OFS_CTRL1, 8'hd0);
      wr(`OFS_EVT, 8'h07);
      waitIrq(1'b0);
      // Slave transfer clocked by the bench, data-in pin idles high
      wr(`OFS_CTRL1, 8'h40);
      wr(`OFS_DATA, tb);
      selDrvN <= 1'b0;
      for (i = 0; i < 8; i++) begin
         repeat (6) @(posedge sys_clk);
         cmp({7'h00, misoOut}, {7'h00, tb[7 - i]});
         sclkDrv <= 1'b1;
         repeat (6) @(posedge sys_clk);
         sclkDrv <= 1'b0;
      end
      repeat (6) @(posedge sys_clk);
      selDrvN <= 1'b1;
      rd(`OFS_STATUS, 8'ha0);
      rd(`OFS_DATA, 8'hff);
      close_out();
   end
endmodule
